// ### tarf_pkg.sv
`default_nettype none
// Shared constants for the tag-access report framer
package tarf_pkg;

	// Register bus geometry
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFS_CTRL = 5'h00; // Write bit0 = start, read bit0 = busy
	localparam logic [4:0] OFS_ACCESS = 5'h04; // Command, tag fault code, reader fault code
	localparam logic [4:0] OFS_FLAGS = 5'h08; // Module and tag error flags
	localparam logic [4:0] OFS_COUNT = 5'h0C; // Written-word tally and tag data length
	localparam logic [4:0] OFS_STATUS = 5'h10; // Busy, bad command, sequence, totals

	// Field positions inside the registers
	localparam int ACC_CMD_LSB = 0;
	localparam int ACC_TAG_LSB = 8;
	localparam int ACC_MOD_LSB = 16;
	localparam int FLG_MOD_BIT = 0;
	localparam int FLG_TAG_BIT = 1;
	localparam int CNT_WWC_LSB = 0;
	localparam int CNT_LEN_LSB = 16;
	localparam int LEN_W = 10;

	// Reset values and CRC polynomial
	localparam logic [7:0] CMD_RST = 8'hC2;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;

	// Packet constants; header signature value is arbitrary
	localparam logic [31:0] PKT_SIGNATURE = 32'h5446524D;
	localparam logic [7:0] RPT_VERSION = 8'h01;
	localparam logic [15:0] RPT_KIND_ACCESS = 16'h0006;

	// Byte positions inside one packet
	localparam logic [5:0] POS_RELNUM = 6'h04;
	localparam logic [5:0] POS_RELSEQ = 6'h05;
	localparam logic [5:0] POS_VER = 6'h06;
	localparam logic [5:0] POS_FLAGS = 6'h07;
	localparam logic [5:0] POS_KIND = 6'h08;
	localparam logic [5:0] POS_INFLEN = 6'h0A;
	localparam logic [5:0] POS_RSEQ = 6'h0C;
	localparam logic [5:0] POS_MS = 6'h0E;
	localparam logic [5:0] POS_CMD = 6'h12;
	localparam logic [5:0] POS_TAGERR = 6'h13;
	localparam logic [5:0] POS_MODERR = 6'h14;
	localparam logic [5:0] POS_WWC = 6'h16;
	localparam logic [5:0] POS_TAG_FIRST = 6'h1A;
	localparam logic [5:0] POS_TAG_LATER = 6'h0E;
	localparam logic [5:0] POS_TAG_END = 6'h3D;
	localparam logic [5:0] POS_CRC_HI = 6'h3E;
	localparam logic [5:0] POS_LAST = 6'h3F;
	localparam logic [10:0] CAP_FIRST = 11'h024;
	localparam logic [10:0] CAP_LATER = 11'h030;
	localparam logic [10:0] HW_LEN = 11'h00C;

	// Access command codes
	localparam logic [7:0] CMD_VEND0 = 8'h30;
	localparam logic [7:0] CMD_VEND1 = 8'h31;
	localparam logic [7:0] CMD_VEND2 = 8'h32;
	localparam logic [7:0] CMD_READ = 8'hC2;
	localparam logic [7:0] CMD_BLK_PERMALOCK = 8'hC9;
	localparam logic [7:0] CMD_UNTRACEABLE = 8'hE0;

	// Tag fault codes
	localparam logic [7:0] TAG_GENERAL = 8'h00;
	localparam logic [7:0] TAG_LOCKED = 8'h04;
	localparam logic [7:0] TAG_LOW_POWER = 8'h0B;
	localparam logic [7:0] TAG_NO_SPECIFIC = 8'h0F;

	// Reader fault codes
	localparam logic [15:0] MOD_NONE = 16'h0000;
	localparam logic [15:0] MOD_BAD_PASSWORD = 16'h0004;
	localparam logic [15:0] MOD_BAD_READ_COUNT = 16'h0008;
	localparam logic [15:0] MOD_LEN_MISMATCH = 16'h000A;
	localparam logic [15:0] MOD_FAILED = 16'hFFFF;

	// Millisecond timebase at 10 MHz
	localparam int MS_TIME_NS = 1000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_TICKS_DEF = MS_TIME_NS / CLK_PERIOD_NS;

	// Tag data buffer
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SIZE = 3'b010,
		ST_EMIT = 3'b100
	} tarf_state_e;

endpackage : tarf_pkg
`default_nettype wire

// ### tarf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Small synchronous FIFO; both ready and valid come from flops
module tarf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic [PW:0] count_next;
	logic ready_reg;
	logic push;
	logic pop;

	// Handshakes on each side
	assign push = in_valid & ready_reg;
	assign pop = out_ready & (count_reg != '0);
	assign count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
	assign in_ready = ready_reg;
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];

	// Write side storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers and occupancy; ready is registered so it has no combinational path from the reader
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + PW'(push);
			rd_ptr_reg <= rd_ptr_reg + PW'(pop);
			count_reg <= count_next;
			ready_reg <= (count_next != (PW+1)'(DEPTH));
		end
	end

endmodule : tarf_fifo
`default_nettype wire

// ### tarf_framer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RQ1] Command byte carries the access command code
// [RQ2] Tag fault code only when tag flag set
// [RQ3] Tag fault codes follow the fixed encoding
// [RQ4] Reader fault code only without tag flag
// [RQ5] Reader codes zero through four as listed
// [RQ6] Read count, retries, length, all-ones failure
// [RQ7] Tally field gives words written to tag
// [RQ8] Reserved bytes always sent as zero
// [RQ9] Tag data only when access had no error
// [RQ10] CRC-16 covers header through padding bytes
// [RQ11] Hardware data only in packet one
// [RQ12] Hardware data fills bytes fourteen to twenty-five
// [RQ13] First packet tag data bytes 26..61
// [RQ14] Later packets tag data bytes 14..61
// [RQ15] Padding only in last packet, flag-sized
// [RQ16] Every packet is sixty-four bytes long
// [RQ17] Flags top bits hold padding byte count
// [RQ18] Report kind field holds six
// [RQ19] Segment index rises one by one
module tarf_framer #(
	parameter int MS_TICKS = tarf_pkg::MS_TICKS_DEF
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [tarf_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [7:0] tag_data,
	input wire logic tag_valid,
	output logic tag_ready,
	output logic [7:0] pkt_data,
	output logic pkt_valid,
	output logic pkt_last,
	input wire logic pkt_ready
);
	import tarf_pkg::*;

	// Configuration written by software, frozen while a report is sent
	logic [7:0] cmd_reg;
	logic [7:0] tag_code_reg;
	logic [15:0] mod_code_reg;
	logic mod_flag_reg;
	logic tag_flag_reg;
	logic [15:0] wwc_reg;
	logic [LEN_W-1:0] len_reg;
	// Sequencer state
	tarf_state_e state_reg;
	logic bad_cmd_reg; // Last start refused for an unknown command
	logic [5:0] idx_reg; // Byte position inside the current packet
	logic [7:0] seq_reg; // Segment index of the current packet
	logic [7:0] relnum_reg; // Total packets of this report
	logic [7:0] sent_reg; // Reports completed since reset
	logic [10:0] size_reg; // Bytes still to place while sizing
	logic [10:0] left_reg; // Tag plus padding bytes still to emit
	logic [15:0] rseq_reg; // Report sequence number
	logic [15:0] crc_reg;
	// Timebase
	logic [31:0] tick_reg;
	logic [31:0] ms_reg;
	logic [31:0] ms_snap_reg;
	// Output stage and read port
	logic [7:0] pkt_data_reg;
	logic pkt_valid_reg;
	logic pkt_last_reg;
	logic [31:0] rdata_reg;

	// Buffer outputs
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic fifo_rd;

	// Bus decode
	wire idle = (state_reg == ST_IDLE);
	wire wr_ctrl = reg_wr & (reg_addr == OFS_CTRL);
	wire cfg_wr = reg_wr & idle; // Config is refused while busy so a report never tears
	wire start_req = wr_ctrl & reg_wdata[0] & idle;

	// Accepts only the documented access commands
	function automatic logic cmd_known(input logic [7:0] c);
		cmd_known = (c >= CMD_VEND0 && c <= CMD_VEND2) ||
			(c >= CMD_READ && c <= CMD_BLK_PERMALOCK) || (c == CMD_UNTRACEABLE); // [RQ1]
	endfunction : cmd_known

	// Tag fault codes outside the list map to the no-specific code
	function automatic logic [7:0] tag_code_fix(input logic [7:0] c);
		if (c <= TAG_LOCKED || c == TAG_LOW_POWER || c == TAG_NO_SPECIFIC) begin
			tag_code_fix = c; // [RQ3]
		end else begin
			tag_code_fix = TAG_NO_SPECIFIC;
		end
	endfunction : tag_code_fix

	// Reader fault codes outside the list map to generic failure
	function automatic logic [15:0] mod_code_fix(input logic [15:0] c);
		if (c <= MOD_BAD_PASSWORD) begin
			mod_code_fix = c; // [RQ5]
		end else if (c >= MOD_BAD_READ_COUNT && c <= MOD_LEN_MISMATCH) begin
			mod_code_fix = c; // [RQ6]
		end else begin
			mod_code_fix = MOD_FAILED; // [RQ6]
		end
	endfunction : mod_code_fix

	// One byte through the CRC-16 shift register, MSB first
	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		crc16_byte = r;
	endfunction : crc16_byte

	// Smaller of two byte counts
	function automatic logic [10:0] min11(input logic [10:0] a, input logic [10:0] b);
		min11 = (a < b) ? a : b;
	endfunction : min11

	// Codes and payload length as sent; an errored access carries no tag data
	wire any_err = mod_flag_reg | tag_flag_reg;
	wire [7:0] eff_tag_code = tag_flag_reg ? tag_code_fix(tag_code_reg) : TAG_GENERAL; // [RQ2]
	wire [15:0] eff_mod_code = (mod_flag_reg & ~tag_flag_reg) ?
		mod_code_fix(mod_code_reg) : MOD_NONE; // [RQ4]
	wire [10:0] eff_len = any_err ? 11'h000 : {1'b0, len_reg}; // [RQ9]
	wire [1:0] pad_cnt = 2'(3'h4 - {1'b0, eff_len[1:0]}); // [RQ17]
	wire [10:0] total = eff_len + {9'h000, pad_cnt};
	wire [7:0] flags_byte = {pad_cnt, 4'h0, tag_flag_reg, mod_flag_reg}; // [RQ17]

	// Packet geometry for the current segment
	wire first_pkt = (seq_reg == 8'h01);
	wire last_pkt = (seq_reg == relnum_reg);
	wire [5:0] tag_start = first_pkt ? POS_TAG_FIRST : POS_TAG_LATER; // [RQ13] [RQ14]
	wire in_region = (idx_reg >= tag_start) && (idx_reg <= POS_TAG_END);
	wire [10:0] pad_ext = {9'h000, pad_cnt};
	wire in_tag = in_region && (left_reg > pad_ext);
	wire [10:0] chunk = min11(left_reg, first_pkt ? CAP_FIRST : CAP_LATER);
	wire [10:0] info_bytes = chunk + (first_pkt ? HW_LEN : 11'h000);
	wire [15:0] inflen = {7'h00, info_bytes[10:2]};

	// Stepping: the output stage must be free and any tag byte present
	wire out_free = ~pkt_valid_reg | pkt_ready;
	wire step = (state_reg == ST_EMIT) & out_free & (~in_tag | fifo_valid);
	wire pkt_end = step & (idx_reg == POS_LAST); // [RQ16]
	assign fifo_rd = step & in_tag;

	// Value of the byte at the current position
	logic [7:0] byte_val;
	always_comb begin
		byte_val = 8'h00; // Reserved bytes and padding stay zero [RQ8] [RQ15]
		if (in_region) begin
			byte_val = in_tag ? fifo_data : 8'h00; // [RQ13] [RQ14]
		end else if (idx_reg == POS_CRC_HI) begin
			byte_val = crc_reg[15:8];
		end else if (idx_reg == POS_LAST) begin
			byte_val = crc_reg[7:0];
		end else begin
			case (idx_reg)
				6'h00: byte_val = PKT_SIGNATURE[31:24];
				6'h01: byte_val = PKT_SIGNATURE[23:16];
				6'h02: byte_val = PKT_SIGNATURE[15:8];
				6'h03: byte_val = PKT_SIGNATURE[7:0];
				POS_RELNUM: byte_val = relnum_reg;
				POS_RELSEQ: byte_val = seq_reg; // [RQ19]
				POS_VER: byte_val = RPT_VERSION;
				POS_FLAGS: byte_val = flags_byte;
				POS_KIND: byte_val = RPT_KIND_ACCESS[15:8]; // [RQ18]
				POS_KIND + 6'h01: byte_val = RPT_KIND_ACCESS[7:0]; // [RQ18]
				POS_INFLEN: byte_val = inflen[15:8];
				POS_INFLEN + 6'h01: byte_val = inflen[7:0];
				POS_RSEQ: byte_val = rseq_reg[15:8];
				POS_RSEQ + 6'h01: byte_val = rseq_reg[7:0];
				// Hardware data, reached only in packet one [RQ11] [RQ12]
				POS_MS: byte_val = ms_snap_reg[31:24];
				POS_MS + 6'h01: byte_val = ms_snap_reg[23:16];
				POS_MS + 6'h02: byte_val = ms_snap_reg[15:8];
				POS_MS + 6'h03: byte_val = ms_snap_reg[7:0];
				POS_CMD: byte_val = cmd_reg; // [RQ1]
				POS_TAGERR: byte_val = eff_tag_code; // [RQ2]
				POS_MODERR: byte_val = eff_mod_code[15:8]; // [RQ4]
				POS_MODERR + 6'h01: byte_val = eff_mod_code[7:0]; // [RQ4]
				POS_WWC: byte_val = wwc_reg[15:8]; // [RQ7]
				POS_WWC + 6'h01: byte_val = wwc_reg[7:0]; // [RQ7]
				default: byte_val = 8'h00; // Reserved word [RQ8]
			endcase
		end
	end

	// Register read mux; unmapped addresses read zero
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			OFS_CTRL: rd_mux = {31'h0, ~idle};
			OFS_ACCESS: rd_mux = {mod_code_reg, tag_code_reg, cmd_reg};
			OFS_FLAGS: rd_mux = {24'h0, flags_byte};
			OFS_COUNT: rd_mux = {6'h00, len_reg, wwc_reg};
			OFS_STATUS: rd_mux = {sent_reg, relnum_reg, seq_reg, 6'h00, bad_cmd_reg, ~idle};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Software-written configuration
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_reg <= CMD_RST;
			tag_code_reg <= TAG_GENERAL;
			mod_code_reg <= MOD_NONE;
			mod_flag_reg <= 1'b0;
			tag_flag_reg <= 1'b0;
			wwc_reg <= 16'h0000;
			len_reg <= '0;
		end else if (cfg_wr) begin
			if (reg_addr == OFS_ACCESS) begin
				cmd_reg <= reg_wdata[ACC_CMD_LSB +: 8];
				tag_code_reg <= reg_wdata[ACC_TAG_LSB +: 8];
				mod_code_reg <= reg_wdata[ACC_MOD_LSB +: 16];
			end
			if (reg_addr == OFS_FLAGS) begin
				mod_flag_reg <= reg_wdata[FLG_MOD_BIT];
				tag_flag_reg <= reg_wdata[FLG_TAG_BIT];
			end
			if (reg_addr == OFS_COUNT) begin
				wwc_reg <= reg_wdata[CNT_WWC_LSB +: 16];
				len_reg <= reg_wdata[CNT_LEN_LSB +: LEN_W];
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	// Free-running millisecond counter, sampled at report start
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_reg <= 32'h0000_0000;
			ms_reg <= 32'h0000_0000;
		end else if (tick_reg == 32'(MS_TICKS - 1)) begin
			tick_reg <= 32'h0000_0000;
			ms_reg <= ms_reg + 32'h0000_0001;
		end else begin
			tick_reg <= tick_reg + 32'h0000_0001;
		end
	end

	// Report sequencer: size the report, then emit packets back to back
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			bad_cmd_reg <= 1'b0;
			idx_reg <= 6'h00;
			seq_reg <= 8'h00;
			relnum_reg <= 8'h00;
			sent_reg <= 8'h00;
			size_reg <= 11'h000;
			left_reg <= 11'h000;
			rseq_reg <= 16'h0000;
			ms_snap_reg <= 32'h0000_0000;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (start_req && !cmd_known(cmd_reg)) begin
						// Unknown command: refuse and flag it
						bad_cmd_reg <= 1'b1;
					end else if (start_req) begin
						bad_cmd_reg <= 1'b0;
						relnum_reg <= 8'h01;
						seq_reg <= 8'h01; // [RQ19]
						idx_reg <= 6'h00;
						left_reg <= total;
						size_reg <= (total > CAP_FIRST) ? (total - CAP_FIRST) : 11'h000; // [RQ13]
						rseq_reg <= rseq_reg + 16'h0001;
						ms_snap_reg <= ms_reg;
						state_reg <= ST_SIZE;
					end
				end
				ST_SIZE: begin
					// One later packet per cycle until all bytes are placed
					if (size_reg == 11'h000) begin
						state_reg <= ST_EMIT;
					end else begin
						relnum_reg <= relnum_reg + 8'h01;
						size_reg <= size_reg - min11(size_reg, CAP_LATER); // [RQ14]
					end
				end
				ST_EMIT: begin
					if (step) begin
						idx_reg <= idx_reg + 6'h01; // Wraps to zero after byte 63 [RQ16]
						if (in_region && left_reg != 11'h000) begin
							left_reg <= left_reg - 11'h001; // Padding follows the last tag byte [RQ15]
						end
					end
					if (pkt_end && last_pkt) begin
						sent_reg <= sent_reg + 8'h01;
						state_reg <= ST_IDLE;
					end else if (pkt_end) begin
						seq_reg <= seq_reg + 8'h01; // [RQ19]
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Running CRC, restarted at each packet boundary
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			crc_reg <= CRC_INIT;
		end else if (idle || pkt_end) begin
			crc_reg <= CRC_INIT;
		end else if (step && idx_reg < POS_CRC_HI) begin
			crc_reg <= crc16_byte(crc_reg, byte_val); // [RQ10]
		end
	end

	// Output stage holds a byte until the sink takes it
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pkt_data_reg <= 8'h00;
			pkt_valid_reg <= 1'b0;
			pkt_last_reg <= 1'b0;
		end else if (step) begin
			pkt_data_reg <= byte_val;
			pkt_valid_reg <= 1'b1;
			pkt_last_reg <= (idx_reg == POS_LAST);
		end else if (pkt_ready) begin
			pkt_valid_reg <= 1'b0;
			pkt_last_reg <= 1'b0;
		end
	end

	assign pkt_data = pkt_data_reg;
	assign pkt_valid = pkt_valid_reg;
	assign pkt_last = pkt_last_reg;
	assign reg_rdata = rdata_reg;

	// Tag data buffer; a slow sink stalls the framer, which stalls the source
	tarf_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.in_data(tag_data),
		.in_valid(tag_valid),
		.in_ready(tag_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_rd)
	);

endmodule : tarf_framer
`default_nettype wire

// ### tarf_framer_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the report framer
module tarf_framer_props #(
	parameter int MS_TICKS = 10
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [tarf_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [7:0] tag_data,
	input wire logic tag_valid,
	input wire logic tag_ready,
	input wire logic [7:0] pkt_data,
	input wire logic pkt_valid,
	input wire logic pkt_last,
	input wire logic pkt_ready
);
	import tarf_pkg::*;
	logic [5:0] bcnt; // Byte index in the packet
	logic [7:0] relnum; // Packet total of current report
	logic [7:0] relseq; // Index of the latest packet
	logic done; // Latest packet closed its report
	wire take = pkt_valid && pkt_ready; // Byte handed over
	// Index wraps every 64 bytes, so a short packet shows up as a misplaced last flag
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bcnt <= 6'h00;
			relnum <= 8'h00;
			relseq <= 8'h00;
			done <= 1'b1;
		end else if (take) begin
			bcnt <= bcnt + 6'h01;
			if (bcnt == POS_RELNUM) relnum <= pkt_data;
			if (bcnt == POS_RELSEQ) relseq <= pkt_data;
			if (bcnt == POS_RELSEQ) done <= (pkt_data == relnum);
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	property p_hold;
		pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data) && $stable(pkt_last);
	endproperty
	a_hold: assert property (p_hold) else $error("packet byte changed while stalled");
	property p_last_pos;
		pkt_valid && pkt_last |-> bcnt == 6'h3F;
	endproperty
	a_last_pos: assert property (p_last_pos) else $error("last flag off byte 63");
	property p_last_need;
		pkt_valid && bcnt == 6'h3F |-> pkt_last;
	endproperty
	a_last_need: assert property (p_last_need) else $error("byte 63 without last flag");
	property p_kind;
		pkt_valid && (bcnt == 6'h08 || bcnt == 6'h09) |-> pkt_data == ((bcnt == 6'h09) ? 8'h06 : 8'h00);
	endproperty
	a_kind: assert property (p_kind) else $error("report kind wrong");
	property p_flag_resv;
		pkt_valid && bcnt == POS_FLAGS |-> pkt_data[5:2] == 4'h0;
	endproperty
	a_flag_resv: assert property (p_flag_resv) else $error("flag reserved bits set");
	property p_resv;
		pkt_valid && relseq == 8'h01 && (bcnt == 6'h18 || bcnt == 6'h19) |-> pkt_data == 8'h00;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved byte not zero");
	property p_seq;
		pkt_valid && bcnt == POS_RELSEQ |-> pkt_data == (done ? 8'h01 : relseq + 8'h01);
	endproperty
	a_seq: assert property (p_seq) else $error("segment index skipped");
	property p_rdata;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside read slot");
endmodule : tarf_framer_props
bind tarf_framer tarf_framer_props #(.MS_TICKS(MS_TICKS)) tarf_framer_props_inst (.core_clk(core_clk),
	.arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .tag_data(tag_data), .tag_valid(tag_valid), .tag_ready(tag_ready),
	.pkt_data(pkt_data), .pkt_valid(pkt_valid), .pkt_last(pkt_last), .pkt_ready(pkt_ready));
`default_nettype wire

// ### tarf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: takes packet bytes with random stalls
module tarf_host_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [7:0] pkt_data,
	input wire logic pkt_valid,
	input wire logic pkt_last,
	output logic pkt_ready
);
	logic [7:0] rx_q[$]; // Bytes taken, in order, read by the bench
	// Stall one cycle in four so held bytes get exercised
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pkt_ready <= 1'b0;
		end else begin
			if (pkt_valid && pkt_ready) rx_q.push_back(pkt_data);
			pkt_ready <= ($urandom % 4) != 0;
		end
	end
endmodule : tarf_host_model
`default_nettype wire

// ### tarf_framer_test.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the report framer
module tarf_framer_test;
	import tarf_pkg::*;
	logic core_clk, arst_n, reg_wr, reg_rd, tag_valid, tag_ready, pkt_valid, pkt_last, pkt_ready;
	logic [4:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [7:0] tag_data, pkt_data;
	logic [7:0] src_q[$]; // Tag bytes waiting to enter the buffer
	logic [15:0] rseq = 16'h0000; // Report sequence of the latest report checked
	logic [31:0] ms_last = 32'h0; // Stamp of the previous report
	int n_mismatch = 0;
	int total_checks = 0;
	logic [7:0] cmds[12] = '{8'h30, 8'h31, 8'h32, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hE0};
	logic [7:0] tcs[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0B, 8'h0F, 8'h55};
	logic [15:0] mcs[10] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h8, 16'h9, 16'hA, 16'hFFFF, 16'h0123};
	int lens[7] = '{1, 2, 3, 36, 37, 84, 85};
	tarf_framer #(.MS_TICKS(10)) tarf_framer_inst (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tag_data(tag_data),
		.tag_valid(tag_valid), .tag_ready(tag_ready), .pkt_data(pkt_data), .pkt_valid(pkt_valid),
		.pkt_last(pkt_last), .pkt_ready(pkt_ready));
	tarf_host_model tarf_host_model_inst (.core_clk(core_clk), .arst_n(arst_n), .pkt_data(pkt_data),
		.pkt_valid(pkt_valid), .pkt_last(pkt_last), .pkt_ready(pkt_ready));
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Source feeder: holds a byte until the buffer takes it
	always @(posedge core_clk) begin
		if (tag_valid && tag_ready) void'(src_q.pop_front());
		tag_valid <= src_q.size() > 0;
		tag_data <= (src_q.size() > 0) ? src_q[0] : 8'($urandom);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : bus_wr
	// Read data is taken in the single cycle after the strobe
	task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : bus_rd
	// Runs one report and compares each packet with a model built here
	task automatic run_rep(input logic [7:0] cmd, input logic [7:0] tc, input logic [15:0] mc,
			input logic [1:0] fl, input int len, input bit fill);
		logic [7:0] strm[$];
		logic [7:0] ex[64];
		logic [7:0] b, tx;
		logic [15:0] wwc, crc, mx;
		int L, pad, n, ch, i, k;
		wwc = 16'($urandom);
		L = (fl != 2'b00) ? 0 : len;
		pad = (4 - L % 4) % 4;
		for (i = 0; i < L; i++) begin
			b = 8'($urandom);
			strm.push_back(b);
			src_q.push_back(b);
		end
		repeat (pad) strm.push_back(8'h00);
		n = (L + pad <= 36) ? 1 : 2 + (L + pad - 37) / 48;
		tx = fl[1] ? ((tc inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h0B}) ? tc : 8'h0F) : 8'h00;
		mx = (fl == 2'b01) ? ((mc inside {[16'h0:16'h4], [16'h8:16'hA]}) ? mc : 16'hFFFF) : 16'h0000;
		if (fill) begin
			repeat (30) @(posedge core_clk);
			check("buffer full", 32'(tag_ready), 32'h0);
		end
		bus_wr(OFS_ACCESS, {mc, tc, cmd});
		bus_wr(OFS_FLAGS, {30'h0, fl});
		bus_wr(OFS_COUNT, {6'h00, 10'(len), wwc});
		bus_wr(OFS_CTRL, 32'h1);
		if (fill) begin
			bus_rd(OFS_STATUS, rv);
			check("busy", 32'(rv[0]), 32'h1);
			bus_wr(OFS_ACCESS, 32'hC4);
		end
		for (i = 0; i < 3000 && tarf_host_model_inst.rx_q.size() < n * 64; i++) @(posedge core_clk);
		if (tarf_host_model_inst.rx_q.size() < n * 64) begin
			check("timeout", 32'h0, 32'h1);
			conclude();
		end
		rseq++;
		for (k = 1; k <= n; k++) begin
			ex = '{default: 8'h00};
			{ex[0], ex[1], ex[2], ex[3]} = PKT_SIGNATURE;
			ex[4] = 8'(n);
			ex[5] = 8'(k);
			ex[6] = RPT_VERSION;
			ex[7] = {2'(pad), 4'h0, fl};
			{ex[8], ex[9]} = RPT_KIND_ACCESS;
			ch = (k == 1) ? 36 : 48;
			if (strm.size() < ch) ch = strm.size();
			{ex[10], ex[11]} = 16'((ch + ((k == 1) ? 12 : 0)) / 4);
			{ex[12], ex[13]} = rseq;
			if (k == 1) begin
				// Millisecond stamp is not modelled, the seen value is trusted
				for (i = 14; i < 18; i++) ex[i] = tarf_host_model_inst.rx_q[i];
				// Reports are far more than one millisecond (10 cycles) apart, so each stamp must be newer
				check("stamp rises", 32'({ex[14], ex[15], ex[16], ex[17]} > ms_last), 32'h1);
				ms_last = {ex[14], ex[15], ex[16], ex[17]};
				ex[18] = cmd;
				ex[19] = tx;
				{ex[20], ex[21]} = mx;
				{ex[22], ex[23]} = wwc;
			end
			for (i = 0; i < ch; i++) ex[i + ((k == 1) ? 26 : 14)] = strm.pop_front();
			crc = CRC_INIT;
			for (i = 0; i < 62; i++) begin
				crc = crc ^ {ex[i], 8'h00};
				repeat (8) crc = crc[15] ? ((crc << 1) ^ CRC_POLY) : (crc << 1);
			end
			{ex[62], ex[63]} = crc;
			for (i = 0; i < 64; i++)
				check("packet byte", 32'(tarf_host_model_inst.rx_q.pop_front()), 32'(ex[i]));
		end
		bus_rd(OFS_STATUS, rv);
		check("busy clear", 32'(rv[0]), 32'h0);
		check("packet total", 32'(rv[23:16]), 32'(n));
	endtask : run_rep
	initial begin
		repeat (90000) @(posedge core_clk);
		check("watchdog", 32'h0, 32'h1);
		conclude();
	end
	initial begin
		arst_n = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		void'($urandom(21208));
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		bus_rd(OFS_ACCESS, rv);
		check("access reset", rv, 32'h000000C2);
		bus_rd(OFS_FLAGS, rv);
		check("flags reset", rv, 32'h0);
		bus_rd(OFS_COUNT, rv);
		check("count reset", rv, 32'h0);
		bus_rd(5'h14, rv);
		check("unmapped read", rv, 32'h0);
		foreach (cmds[i]) run_rep(cmds[i], 8'h00, 16'h0000, 2'b00, 0, 1'b0);
		// Module flag beside the tag flag must keep the reader code at zero
		foreach (tcs[i]) run_rep(8'hC3, tcs[i], 16'h0003, 2'b11, 8, 1'b0);
		foreach (mcs[i]) run_rep(8'hC4, 8'h04, mcs[i], 2'b01, 8, 1'b0);
		foreach (lens[i]) run_rep(8'hC2, 8'h00, 16'h0000, 2'b00, lens[i], 1'b0);
		// Buffer filled until refused, then drained under host stalls
		run_rep(8'hC2, 8'h00, 16'h0000, 2'b00, 120, 1'b1);
		check("buffer drained", 32'(tag_ready), 32'h1);
		bus_rd(OFS_ACCESS, rv);
		check("busy write dropped", 32'(rv[7:0]), 32'hC2);
		bus_wr(OFS_ACCESS, 32'h55);
		bus_wr(OFS_CTRL, 32'h1);
		repeat (80) @(posedge core_clk);
		bus_rd(OFS_STATUS, rv);
		check("bad command", 32'(rv[1]), 32'h1);
		check("nothing sent", 32'(tarf_host_model_inst.rx_q.size()), 32'h0);
		conclude();
	end
endmodule : tarf_framer_test
`default_nettype wire
